//--- design/mcs_config_sign.sv
// APB register bank for power sign flags and datapath configuration
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/100ps
// Summary of operation
// - Sign bit 7 is 1 when the second pulse datapath power sum is negative, else 0.
// - The second pulse sum uses phase terms 5:3 and source select 5:3.
// - Sign bit 8 is 1 when the third pulse datapath power sum is negative, else 0.
// - The third pulse sum uses phase terms 8:6 and source select 8:6.
// - Sign register bits 15:9 always read zero.
// - Configuration bit 0 routes all four currents through the integrator, else bypass.
// - Configuration bit 3 swaps voltage and current channel outputs.
// - Configuration bit 4 makes the voltage converters read as grounded.
// - Configuration bit 5 makes the current converters read as grounded.
// - Configuration bit 6 enables the fast capture port and its clock on the shared pin.
// - With bit 6 clear the port is off and the shared pin carries the third pulse.
// - Writing 1 to configuration bit 7 starts a software reset.
// - Bits 9:8 pick the voltage for phase A current: A, B, C, and 11 acts as A.
// - Bits 11:10 pick the voltage for phase B current: B, C, A, and 11 acts as B.
// - Bits 13:12 pick the voltage for phase C current: C, A, B, and 11 acts as C.
// - Bits 2:1 and 15:14 do nothing and every field resets to zero.
module mcs_config_sign (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`MCS_ADDR_W-1:0] paddr,
    input wire logic [`MCS_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [`MCS_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire mcs_pkg::mcs_reg_t compensation_mode_register,
    input wire mcs_pkg::mcs_reg_t pulse_output_mode_register,
    input wire mcs_pkg::mcs_sample_t active_power_a,
    input wire mcs_pkg::mcs_sample_t active_power_b,
    input wire mcs_pkg::mcs_sample_t active_power_c,
    input wire mcs_pkg::mcs_sample_t reactive_power_a,
    input wire mcs_pkg::mcs_sample_t reactive_power_b,
    input wire mcs_pkg::mcs_sample_t reactive_power_c,
    input wire mcs_pkg::mcs_sample_t apparent_power_a,
    input wire mcs_pkg::mcs_sample_t apparent_power_b,
    input wire mcs_pkg::mcs_sample_t apparent_power_c,
    input wire mcs_pkg::mcs_sample_t voltage_sample_a,
    input wire mcs_pkg::mcs_sample_t voltage_sample_b,
    input wire mcs_pkg::mcs_sample_t voltage_sample_c,
    input wire mcs_pkg::mcs_sample_t current_sample_a,
    input wire mcs_pkg::mcs_sample_t current_sample_b,
    input wire mcs_pkg::mcs_sample_t current_sample_c,
    input wire mcs_pkg::mcs_sample_t current_sample_n,
    output mcs_pkg::mcs_sample_t voltage_channel_a,
    output mcs_pkg::mcs_sample_t voltage_channel_b,
    output mcs_pkg::mcs_sample_t voltage_channel_c,
    output mcs_pkg::mcs_sample_t current_channel_a,
    output mcs_pkg::mcs_sample_t current_channel_b,
    output mcs_pkg::mcs_sample_t current_channel_c,
    output mcs_pkg::mcs_sample_t current_channel_n,
    output mcs_pkg::mcs_sample_t voltage_for_phase_a_current,
    output mcs_pkg::mcs_sample_t voltage_for_phase_b_current,
    output mcs_pkg::mcs_sample_t voltage_for_phase_c_current,
    input wire logic third_pulse_output,
    input wire logic fast_capture_clock,
    output logic shared_pulse_pin,
    output logic fast_capture_port_enable,
    output logic integrator_enable,
    output logic voltage_adc_ground_force,
    output logic current_adc_ground_force,
    output logic software_reset_active
);
    import mcs_pkg::*;

    localparam int NCUR = 4;
    localparam int NVOLT = 3;

    mcs_reg_t cfg_ff;
    mcs_state_t state_ff;
    mcs_state_t nxt_state;
    logic [`MCS_CNT_W-1:0] rst_cnt_ff;
    logic second_pulse_sum_negative_ff;
    logic third_pulse_sum_negative_ff;
    logic second_neg;
    logic third_neg;
    logic pin_ff;

    mcs_sample_t cur_in [NCUR];
    mcs_sample_t cur_gnd [NCUR];
    mcs_sample_t cur_proc [NCUR];
    mcs_sample_t cur_out_ff [NCUR];
    logic signed [`MCS_INTEG_W-1:0] integ_ff [NCUR];
    mcs_sample_t volt_in [NVOLT];
    mcs_sample_t volt_gnd [NVOLT];
    mcs_sample_t volt_out_ff [NVOLT];
    mcs_sample_t volt_sel_ff [NVOLT];

    logic in_reset;
    logic access;
    logic [`MCS_IDX_HI-`MCS_IDX_LO:0] reg_idx;
    logic hit_sign;
    logic hit_cfg;
    logic cfg_write;
    mcs_reg_t wmask;
    mcs_reg_t sign_view;
    mcs_reg_t cfg_view;
    logic software_reset_trigger_req;

    assign in_reset = (state_ff == MCS_ST_SOFTWARE_RESET_TRIGGER);

    // APB decode; the slave never inserts wait states
    assign access = psel & penable;
    assign reg_idx = paddr[`MCS_IDX_HI:`MCS_IDX_LO];
    assign hit_sign = (reg_idx == `MCS_SIGN_IDX) && (paddr[1:0] == 2'h0);
    assign hit_cfg = (reg_idx == `MCS_CFG_IDX) && (paddr[1:0] == 2'h0);
    assign pready = 1'b1;
    assign pslverr = access & ~(hit_sign | hit_cfg);
    // Writes during a software reset are dropped so the reset ends in defaults
    assign cfg_write = access & pwrite & hit_cfg & ~in_reset;
    assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}} & `MCS_CFG_WMASK;
    assign software_reset_trigger_req = cfg_write & pstrb[0] & pwdata[`MCS_CFG_SOFTWARE_RESET_TRIGGER];

    always_comb begin
        sign_view = '0;
        sign_view[`MCS_SUM2_BIT] = second_pulse_sum_negative_ff;
        sign_view[`MCS_SUM3_BIT] = third_pulse_sum_negative_ff;
    end

    // reset bit reads 1 only while active
    always_comb begin
        cfg_view = cfg_ff;
        cfg_view[`MCS_CFG_SOFTWARE_RESET_TRIGGER] = in_reset;
    end

    always_comb begin
        prdata = '0;
        if (access & ~pwrite & hit_sign) begin
            prdata = {16'h0000, sign_view};
        end else if (access & ~pwrite & hit_cfg) begin
            prdata = {16'h0000, cfg_view};
        end
    end

    // reserved bits never stored, defaults zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff <= `MCS_CFG_RESET;
        end else if (in_reset) begin
            cfg_ff <= `MCS_CFG_RESET;
        end else if (cfg_write) begin
            cfg_ff <= (cfg_ff & ~wmask) | (pwdata[`MCS_REG_W-1:0] & wmask);
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            MCS_ST_RUN: begin
                if (software_reset_trigger_req) begin
                    nxt_state = MCS_ST_SOFTWARE_RESET_TRIGGER;
                end
            end
            MCS_ST_SOFTWARE_RESET_TRIGGER: begin
                if (rst_cnt_ff == `MCS_CNT_W'(`MCS_SOFTWARE_RESET_TRIGGER_CYCLES - 1)) begin
                    nxt_state = MCS_ST_RUN;
                end
            end
            default: begin
                nxt_state = MCS_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= MCS_ST_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cnt_ff <= '0;
        end else if (in_reset) begin
            rst_cnt_ff <= rst_cnt_ff + `MCS_CNT_W'(1);
        end else begin
            rst_cnt_ff <= '0;
        end
    end

    assign software_reset_active = in_reset;

    mcs_sum_sign u_sum2 (
        .phase_terms(compensation_mode_register[`MCS_TERM2_LO+2:`MCS_TERM2_LO]),
        .source_select(pulse_output_mode_register[`MCS_SRC2_LO+2:`MCS_SRC2_LO]),
        .active_a(active_power_a),
        .active_b(active_power_b),
        .active_c(active_power_c),
        .reactive_a(reactive_power_a),
        .reactive_b(reactive_power_b),
        .reactive_c(reactive_power_c),
        .apparent_a(apparent_power_a),
        .apparent_b(apparent_power_b),
        .apparent_c(apparent_power_c),
        .sum_negative(second_neg)
    );

    mcs_sum_sign u_sum3 (
        .phase_terms(compensation_mode_register[`MCS_TERM3_LO+2:`MCS_TERM3_LO]),
        .source_select(pulse_output_mode_register[`MCS_SRC3_LO+2:`MCS_SRC3_LO]),
        .active_a(active_power_a),
        .active_b(active_power_b),
        .active_c(active_power_c),
        .reactive_a(reactive_power_a),
        .reactive_b(reactive_power_b),
        .reactive_c(reactive_power_c),
        .apparent_a(apparent_power_a),
        .apparent_b(apparent_power_b),
        .apparent_c(apparent_power_c),
        .sum_negative(third_neg)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            second_pulse_sum_negative_ff <= 1'b0;
            third_pulse_sum_negative_ff <= 1'b0;
        end else if (in_reset) begin
            second_pulse_sum_negative_ff <= 1'b0;
            third_pulse_sum_negative_ff <= 1'b0;
        end else begin
            second_pulse_sum_negative_ff <= second_neg;
            third_pulse_sum_negative_ff <= third_neg;
        end
    end

    assign integrator_enable = cfg_ff[`MCS_CFG_INTEGRATOR_ENABLE];
    assign voltage_adc_ground_force = cfg_ff[`MCS_CFG_VGND];
    assign current_adc_ground_force = cfg_ff[`MCS_CFG_IGND];
    assign fast_capture_port_enable = cfg_ff[`MCS_CFG_FAST];

    assign cur_in[0] = current_sample_a;
    assign cur_in[1] = current_sample_b;
    assign cur_in[2] = current_sample_c;
    assign cur_in[3] = current_sample_n;
    assign volt_in[0] = voltage_sample_a;
    assign volt_in[1] = voltage_sample_b;
    assign volt_in[2] = voltage_sample_c;

    genvar gi;
    generate
        for (gi = 0; gi < NCUR; gi++) begin : g_cur
            assign cur_gnd[gi] = cfg_ff[`MCS_CFG_IGND] ? '0 : cur_in[gi];

            // Leaky accumulator keeps DC offsets from winding the sum up
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    integ_ff[gi] <= '0;
                end else if (in_reset | ~cfg_ff[`MCS_CFG_INTEGRATOR_ENABLE]) begin
                    integ_ff[gi] <= '0;
                end else begin
                    integ_ff[gi] <= integ_ff[gi] - (integ_ff[gi] >>> `MCS_INTEG_SHIFT)
                        + `MCS_INTEG_W'(cur_gnd[gi]);
                end
            end

            assign cur_proc[gi] = cfg_ff[`MCS_CFG_INTEGRATOR_ENABLE]
                ? integ_ff[gi][`MCS_INTEG_W-1:`MCS_INTEG_SHIFT] : cur_gnd[gi];
        end

        for (gi = 0; gi < NVOLT; gi++) begin : g_volt
            assign volt_gnd[gi] = cfg_ff[`MCS_CFG_VGND] ? '0 : volt_in[gi];

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    volt_out_ff[gi] <= '0;
                    cur_out_ff[gi] <= '0;
                end else if (cfg_ff[`MCS_CFG_SWAP]) begin
                    volt_out_ff[gi] <= cur_proc[gi];
                    cur_out_ff[gi] <= volt_gnd[gi];
                end else begin
                    volt_out_ff[gi] <= volt_gnd[gi];
                    cur_out_ff[gi] <= cur_proc[gi];
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    volt_sel_ff[gi] <= '0;
                end else begin
                    case (mcs_vsel_t'(cfg_ff[`MCS_CFG_VOLTAGE_FOR_PHASE_A_CURRENT + 2*gi +: 2]))
                        MCS_VSEL_NEXT: volt_sel_ff[gi] <= volt_out_ff[(gi + 1) % NVOLT];
                        MCS_VSEL_PREV: volt_sel_ff[gi] <= volt_out_ff[(gi + 2) % NVOLT];
                        default: volt_sel_ff[gi] <= volt_out_ff[gi];
                    endcase
                end
            end
        end
    endgenerate

    // Neutral has no voltage partner, so the swap leaves it alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_out_ff[3] <= '0;
        end else begin
            cur_out_ff[3] <= cur_proc[3];
        end
    end

    assign voltage_channel_a = volt_out_ff[0];
    assign voltage_channel_b = volt_out_ff[1];
    assign voltage_channel_c = volt_out_ff[2];
    assign current_channel_a = cur_out_ff[0];
    assign current_channel_b = cur_out_ff[1];
    assign current_channel_c = cur_out_ff[2];
    assign current_channel_n = cur_out_ff[3];
    assign voltage_for_phase_a_current = volt_sel_ff[0];
    assign voltage_for_phase_b_current = volt_sel_ff[1];
    assign voltage_for_phase_c_current = volt_sel_ff[2];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_ff <= 1'b0;
        end else if (cfg_ff[`MCS_CFG_FAST]) begin
            pin_ff <= fast_capture_clock;
        end else begin
            pin_ff <= third_pulse_output;
        end
    end

    assign shared_pulse_pin = pin_ff;
endmodule

//--- include/mcs_defs.svh
// Register map, field positions and timing constants of the meter configuration block
`ifndef MCS_DEFS_SVH
`define MCS_DEFS_SVH

`define MCS_ADDR_W 18
`define MCS_DATA_W 32
`define MCS_REG_W 16
`define MCS_SAMPLE_W 24
`define MCS_INTEG_W 32

`define MCS_SIGN_IDX 16'he617
`define MCS_CFG_IDX 16'he618
`define MCS_IDX_HI 17
`define MCS_IDX_LO 2

`define MCS_SUM2_BIT 7
`define MCS_SUM3_BIT 8
`define MCS_CFG_INTEGRATOR_ENABLE 0
`define MCS_CFG_SWAP 3
`define MCS_CFG_VGND 4
`define MCS_CFG_IGND 5
`define MCS_CFG_FAST 6
`define MCS_CFG_SOFTWARE_RESET_TRIGGER 7
`define MCS_CFG_VOLTAGE_FOR_PHASE_A_CURRENT 8
`define MCS_CFG_VOLTAGE_FOR_PHASE_B_CURRENT 10
`define MCS_CFG_VOLTAGE_FOR_PHASE_C_CURRENT 12
`define MCS_CFG_RESET 16'h0000
`define MCS_CFG_WMASK 16'h3ff9

`define MCS_TERM2_LO 3
`define MCS_TERM3_LO 6
`define MCS_SRC2_LO 3
`define MCS_SRC3_LO 6

`define MCS_INTEG_SHIFT 8
`define MCS_CLK_PERIOD_NS 10
`define MCS_SOFTWARE_RESET_TRIGGER_TIME_NS 80
`define MCS_SOFTWARE_RESET_TRIGGER_CYCLES ((`MCS_SOFTWARE_RESET_TRIGGER_TIME_NS + `MCS_CLK_PERIOD_NS - 1) / `MCS_CLK_PERIOD_NS)
`define MCS_CNT_W 4

`endif

//--- include/mcs_pkg.sv
// Types shared by the meter configuration block
package mcs_pkg;
`include "mcs_defs.svh"

    typedef logic signed [`MCS_SAMPLE_W-1:0] mcs_sample_t;
    typedef logic [`MCS_REG_W-1:0] mcs_reg_t;

    typedef enum logic [1:0] {
        MCS_ST_RUN = 2'b01,
        MCS_ST_SOFTWARE_RESET_TRIGGER = 2'b10
    } mcs_state_t;

    typedef enum logic [2:0] {
        MCS_SRC_ACTIVE = 3'h0,
        MCS_SRC_REACTIVE = 3'h1,
        MCS_SRC_APPARENT = 3'h2
    } mcs_src_t;

    typedef enum logic [1:0] {
        MCS_VSEL_OWN = 2'h0,
        MCS_VSEL_NEXT = 2'h1,
        MCS_VSEL_PREV = 2'h2
    } mcs_vsel_t;
endpackage

//--- design/mcs_sum_sign.sv
// Sign of the summed phase powers feeding one pulse-output datapath
`timescale 1ns/100ps
module mcs_sum_sign (
    input wire logic [2:0] phase_terms,
    input wire logic [2:0] source_select,
    input wire mcs_pkg::mcs_sample_t active_a,
    input wire mcs_pkg::mcs_sample_t active_b,
    input wire mcs_pkg::mcs_sample_t active_c,
    input wire mcs_pkg::mcs_sample_t reactive_a,
    input wire mcs_pkg::mcs_sample_t reactive_b,
    input wire mcs_pkg::mcs_sample_t reactive_c,
    input wire mcs_pkg::mcs_sample_t apparent_a,
    input wire mcs_pkg::mcs_sample_t apparent_b,
    input wire mcs_pkg::mcs_sample_t apparent_c,
    output logic sum_negative
);
    import mcs_pkg::*;

    // Two guard bits: three full-scale terms cannot overflow the sum
    logic signed [`MCS_SAMPLE_W+1:0] sum;
    mcs_sample_t pick_a;
    mcs_sample_t pick_b;
    mcs_sample_t pick_c;

    always_comb begin
        case (source_select)
            MCS_SRC_REACTIVE: begin
                pick_a = reactive_a;
                pick_b = reactive_b;
                pick_c = reactive_c;
            end
            MCS_SRC_APPARENT: begin
                pick_a = apparent_a;
                pick_b = apparent_b;
                pick_c = apparent_c;
            end
            // Unused codes fall back to active power
            default: begin
                pick_a = active_a;
                pick_b = active_b;
                pick_c = active_c;
            end
        endcase
    end

    always_comb begin
        sum = '0;
        if (phase_terms[0]) begin
            sum = sum + (`MCS_SAMPLE_W+2)'(pick_a);
        end
        if (phase_terms[1]) begin
            sum = sum + (`MCS_SAMPLE_W+2)'(pick_b);
        end
        if (phase_terms[2]) begin
            sum = sum + (`MCS_SAMPLE_W+2)'(pick_c);
        end
    end

    // A zero sum counts as positive
    assign sum_negative = sum[`MCS_SAMPLE_W+1];
endmodule

//--- bench/mcs_config_sign_props.sv
// Concurrent checks on the configuration and sign register bank
`timescale 1ns/100ps
`include "mcs_defs.svh"
module mcs_config_sign_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`MCS_ADDR_W-1:0] paddr,
    input wire logic [`MCS_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [`MCS_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic third_pulse_output,
    input wire logic fast_capture_clock,
    input wire logic shared_pulse_pin,
    input wire logic fast_capture_port_enable,
    input wire logic integrator_enable,
    input wire logic voltage_adc_ground_force,
    input wire logic current_adc_ground_force,
    input wire logic software_reset_active
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd_sg, rd_cf, wr_cf;
    assign rd_sg = psel && penable && !pwrite && paddr == {`MCS_SIGN_IDX, 2'b00};
    assign rd_cf = psel && penable && !pwrite && paddr == {`MCS_CFG_IDX, 2'b00};
    // Writes during a software reset are dropped, so they are left out
    assign wr_cf = psel && penable && pwrite && pready && pstrb[0] && !software_reset_active
        && paddr == {`MCS_CFG_IDX, 2'b00};
    sign_resv_a: assert property (rd_sg |-> prdata[31:9] == '0)
        else $error("sign register high bits not zero");
    cfg_resv_a: assert property (rd_cf |-> prdata[2:1] == '0 && prdata[31:14] == '0)
        else $error("reserved configuration bits not zero");
    cfg_live_a: assert property (rd_cf |-> prdata[0] == integrator_enable
        && prdata[6:4] == {fast_capture_port_enable, current_adc_ground_force,
        voltage_adc_ground_force} && prdata[7] == software_reset_active)
        else $error("configuration readback differs from outputs");
    integ_wr_a: assert property (wr_cf |=> integrator_enable == $past(pwdata[0]))
        else $error("integrator enable not written");
    gnd_wr_a: assert property (wr_cf |=> {current_adc_ground_force,
        voltage_adc_ground_force} == $past(pwdata[5:4]))
        else $error("ground force bits not written");
    fast_wr_a: assert property (wr_cf |=> fast_capture_port_enable == $past(pwdata[6]))
        else $error("fast capture enable not written");
    fast_pin_a: assert property ($past(presetn, 2) && $past(fast_capture_port_enable)
        |-> shared_pulse_pin == $past(fast_capture_clock))
        else $error("shared pin does not carry fast clock");
    pulse_pin_a: assert property ($past(presetn, 2) && !$past(fast_capture_port_enable)
        |-> shared_pulse_pin == $past(third_pulse_output))
        else $error("shared pin does not carry third pulse");
    software_reset_trigger_len_a: assert property (wr_cf && pwdata[7]
        |=> software_reset_active [*8] ##1 !software_reset_active)
        else $error("software reset length wrong");
    software_reset_trigger_end_a: assert property ($fell(software_reset_active) |-> !integrator_enable
        && !fast_capture_port_enable && !voltage_adc_ground_force && !current_adc_ground_force)
        else $error("configuration not cleared by software reset");
    cover property (wr_cf && pwdata[7]);
    cover property (rd_sg && prdata[8:7] == 2'b11);
    cover property (rd_cf && prdata[6]);
endmodule

bind mcs_config_sign mcs_config_sign_props i_props (.*);

//--- bench/tb_mcs_config_sign.sv
// Self-checking bench for the configuration and sign register bank
`timescale 1ns/100ps
`include "mcs_defs.svh"
module tb_mcs_config_sign;
    import mcs_pkg::*;
    localparam logic [17:0] SGN = {`MCS_SIGN_IDX, 2'b00};
    localparam logic [17:0] CFG = {`MCS_CFG_IDX, 2'b00};
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tpo = 0, fcc = 0;
    logic [17:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [3:0] pstrb = '0;
    logic pready, pslverr, pin, fen, ien, vgf, igf, swa;
    mcs_reg_t cmr = '0, pmr = '0;
    mcs_sample_t pw[3][3], vs[3], cs[4], vc[3], cc[4], vp[3];
    logic [32:0] exq[$];
    int error_cnt = 0, cmp_count = 0, seed = 78;

    always #5 pclk = ~pclk;

    mcs_config_sign i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .compensation_mode_register(cmr),
        .pulse_output_mode_register(pmr), .active_power_a(pw[0][0]),
        .active_power_b(pw[0][1]), .active_power_c(pw[0][2]), .reactive_power_a(pw[1][0]),
        .reactive_power_b(pw[1][1]), .reactive_power_c(pw[1][2]),
        .apparent_power_a(pw[2][0]), .apparent_power_b(pw[2][1]),
        .apparent_power_c(pw[2][2]), .voltage_sample_a(vs[0]), .voltage_sample_b(vs[1]),
        .voltage_sample_c(vs[2]), .current_sample_a(cs[0]), .current_sample_b(cs[1]),
        .current_sample_c(cs[2]), .current_sample_n(cs[3]), .voltage_channel_a(vc[0]),
        .voltage_channel_b(vc[1]), .voltage_channel_c(vc[2]), .current_channel_a(cc[0]),
        .current_channel_b(cc[1]), .current_channel_c(cc[2]), .current_channel_n(cc[3]),
        .voltage_for_phase_a_current(vp[0]), .voltage_for_phase_b_current(vp[1]),
        .voltage_for_phase_c_current(vp[2]), .third_pulse_output(tpo),
        .fast_capture_clock(fcc), .shared_pulse_pin(pin), .fast_capture_port_enable(fen),
        .integrator_enable(ien), .voltage_adc_ground_force(vgf),
        .current_adc_ground_force(igf), .software_reset_active(swa));

    task chk(input logic [32:0] got, input logic [32:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Read expectations go to the queue; the monitor below settles them
    task apb(input logic wr, input logic [17:0] a, input logic [31:0] d,
            input logic [3:0] s, input logic [32:0] e);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        if (!wr)
            exq.push_back(e);
        @(posedge pclk);
        penable <= 1;
        // Wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
    endtask

    task wt(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    function int src(input logic [2:0] c);
        return (c > 2) ? 0 : int'(c);
    endfunction

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exq.size() == 0) begin
                error_cnt++;
                $display("[FAIL] %0t read with no expected value", $time);
            end else
                chk({pslverr, prdata}, exq.pop_front());
        end
    end

    // Shared pin sources toggle freely; the checker follows the mux
    always @(posedge pclk) begin
        tpo <= 1'($random(seed));
        fcc <= 1'($random(seed));
    end

    initial begin
        #100us;
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        final_report;
    end

    initial begin
        logic [15:0] cf, d;
        logic [3:0] st;
        int s2, s3, k;
        mcs_sample_t ev[3], ec;
        foreach (pw[i, j]) pw[i][j] = '0;
        foreach (vs[i]) vs[i] = '0;
        foreach (cs[i]) cs[i] = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1;
        apb(0, CFG, 0, 0, 33'h0);
        apb(0, SGN, 0, 0, 33'h0);
        apb(0, 18'h00010, 0, 0, {1'b1, 32'h0});
        $display("reset values done");
        cf = '0;
        for (k = 0; k < 10; k++) begin
            d = 16'($random(seed)) & 16'hff7f;
            st = 4'($random(seed));
            if (st[0])
                cf[7:0] = d[7:0];
            if (st[1])
                cf[15:8] = d[15:8];
            cf = cf & 16'h3f79;
            apb(1, CFG, {16'h0, d}, st, 0);
            apb(0, CFG, 0, 0, {17'h0, cf});
            chk({fen, igf, vgf, ien}, {cf[6:4], cf[0]});
        end
        $display("configuration access done");
        for (k = 0; k < 12; k++) begin
            @(posedge pclk);
            cmr <= 16'($random(seed));
            pmr <= 16'($random(seed));
            foreach (pw[i, j]) pw[i][j] <= 24'($random(seed));
            wt(2);
            s2 = 0;
            s3 = 0;
            for (int p = 0; p < 3; p++) begin
                if (cmr[3 + p])
                    s2 += pw[src(pmr[5:3])][p];
                if (cmr[6 + p])
                    s3 += pw[src(pmr[8:6])][p];
            end
            apb(1, SGN, 32'h1ff80, 4'hf, 0);
            apb(0, SGN, 0, 0, {24'h0, s3 < 0, s2 < 0, 7'h0});
        end
        $display("sign flags done");
        for (k = 0; k < 4; k++) begin
            d = {2'b00, {3{k[1:0]}}, 2'b00, k == 3, k == 2, k == 1, 3'b000};
            apb(1, CFG, {16'h0, d}, 4'h3, 0);
            @(posedge pclk);
            foreach (vs[i]) vs[i] <= 24'($random(seed));
            foreach (cs[i]) cs[i] <= 24'($random(seed));
            wt(4);
            for (int p = 0; p < 3; p++) begin
                ev[p] = (k == 1) ? cs[p] : (k == 2) ? '0 : vs[p];
                ec = (k == 1) ? vs[p] : (k == 3) ? '0 : cs[p];
                chk(vc[p], ev[p]);
                chk(cc[p], ec);
            end
            ec = (k == 3) ? '0 : cs[3];
            chk(cc[3], ec);
            for (int p = 0; p < 3; p++)
                chk(vp[p], ev[(p + k % 3) % 3]);
        end
        @(posedge pclk);
        foreach (cs[i]) cs[i] <= 24'($random(seed) % 1000);
        apb(1, CFG, 32'h1, 4'h3, 0);
        // A constant input settles the leaky integrator at that same value
        wt(3000);
        foreach (cs[i]) chk(cc[i], cs[i]);
        $display("datapath routing done");
        apb(1, CFG, 32'h41, 4'h1, 0);
        apb(1, CFG, 32'h80, 4'h1, 0);
        wt(1);
        chk(swa, 1'b1);
        apb(1, CFG, 32'h1, 4'h1, 0);
        apb(0, CFG, 0, 0, 33'h80);
        k = 0;
        while (swa === 1'b1 && k < 50) begin
            @(posedge pclk);
            k++;
        end
        apb(0, CFG, 0, 0, 33'h0);
        $display("software reset done");
        wt(2);
        final_report;
    end
endmodule
